/* File: hdl/pqx_device.sv */
`timescale 1ns/10ps
// Behaviour
// - sixteen quasi-bidirectional lines, no direction control
// - all lines high impedance after reset
// - strong pull-up on written high until fall
// - host writes one before using input
// - alert open-drain low, valid after delay
// - any input line edge raises alert
// - alert clears on restore or access
// - clear at ack: read rise, write fall
// - later changes raise alert again
// - other devices' transfers leave alert alone
// - bytes pair low port then high
// - write drives lines after second ack
// - unlimited write pairs, each replaces latches
// - read returns sampled pins, low first
// - no buffering of input changes
// - reset returns bus machine to idle
// - three select pins set address bits
// - general call address is never acknowledged
// - only acknowledged complete bytes update latches
// - select pins steady during a transfer
module pqx_device (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       sys_rst,
    // serial bus
    pqx_if.device           bus,
    // address select straps
    input  wire logic       addr_select_bit0,
    input  wire logic       addr_select_bit1,
    input  wire logic       addr_select_bit2,
    // port lines
    input  wire logic [7:0] port_low_byte_lines_i,
    output logic      [7:0] port_low_byte_lines_o,
    output logic      [7:0] port_low_byte_lines_oe,
    input  wire logic [7:0] port_high_byte_lines_i,
    output logic      [7:0] port_high_byte_lines_o,
    output logic      [7:0] port_high_byte_lines_oe
);

    logic                    scl_meta_reg, scl_s_reg, scl_d_reg;
    logic                    sda_meta_reg, sda_s_reg, sda_d_reg;
    logic [15:0]             pin_meta_reg, pin_s_reg;
    logic [2:0]              asel_meta_reg, asel_s_reg;
    pqx_pkg::pqx_dev_state_t state_reg, state_next;
    logic [3:0]              cnt_reg, cnt_next;
    logic [7:0]              shift_reg, shift_next;
    logic                    idx_reg, idx_next;
    logic [7:0]              lo_hold_reg, lo_hold_next;
    logic [15:0]             snap_reg, snap_next;
    logic [15:0]             latch_reg, latch_next;
    logic [15:0]             strong_reg, strong_next;
    logic                    sda_oe_reg, sda_oe_next;
    logic [15:0]             ref_reg, ref_next;
    logic [7:0]              alert_cnt_reg, alert_cnt_next;
    logic                    alert_reg, alert_next;
    logic                    scl_rise, scl_fall, start_cond, stop_cond, addr_match, mismatch, clear_alert;
    logic [7:0]              rd_byte;

    // synchronisers for bus, port and strap inputs
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            scl_meta_reg  <= 1'b1;
            scl_s_reg     <= 1'b1;
            scl_d_reg     <= 1'b1;
            sda_meta_reg  <= 1'b1;
            sda_s_reg     <= 1'b1;
            sda_d_reg     <= 1'b1;
            pin_meta_reg  <= '1;
            pin_s_reg     <= '1;
            asel_meta_reg <= '0;
            asel_s_reg    <= '0;
        end else begin
            scl_meta_reg  <= bus.scl;
            scl_s_reg     <= scl_meta_reg;
            scl_d_reg     <= scl_s_reg;
            sda_meta_reg  <= bus.sda;
            sda_s_reg     <= sda_meta_reg;
            sda_d_reg     <= sda_s_reg;
            pin_meta_reg  <= {port_high_byte_lines_i, port_low_byte_lines_i};
            pin_s_reg     <= pin_meta_reg;
            asel_meta_reg <= {addr_select_bit2, addr_select_bit1, addr_select_bit0};
            asel_s_reg    <= asel_meta_reg;
        end
    end

    assign scl_rise   = scl_s_reg & ~scl_d_reg;
    assign scl_fall   = ~scl_s_reg & scl_d_reg;
    // scl must have been high a cycle already, so data moving with a clock edge is not a start or stop
    assign start_cond = ~sda_s_reg & sda_d_reg & scl_s_reg & scl_d_reg;
    assign stop_cond  = sda_s_reg & ~sda_d_reg & scl_s_reg & scl_d_reg;
    assign addr_match = (shift_reg[7:4] == pqx_pkg::ADDR_PREFIX)
                      & (shift_reg[3:1] == asel_s_reg)
                      & (shift_reg[7:1] != pqx_pkg::GENERAL_CALL_ADDR);
    assign mismatch   = |((pin_s_reg ^ ref_reg) & latch_reg);
    assign rd_byte    = idx_reg ? snap_reg[15:8] : pin_s_reg[7:0];

    always_comb begin
        state_next   = state_reg;
        cnt_next     = cnt_reg;
        shift_next   = shift_reg;
        idx_next     = idx_reg;
        lo_hold_next = lo_hold_reg;
        snap_next    = snap_reg;
        latch_next   = latch_reg;
        strong_next  = scl_fall ? '0 : strong_reg;
        sda_oe_next  = sda_oe_reg;
        clear_alert  = 1'b0;
        if (start_cond) begin
            state_next  = pqx_pkg::PQX_DEV_ADDR;
            cnt_next    = '0;
            idx_next    = 1'b0;
            sda_oe_next = 1'b0;
        end else if (stop_cond) begin
            state_next  = pqx_pkg::PQX_DEV_IDLE;
            sda_oe_next = 1'b0;
        end else if (scl_rise) begin
            unique case (state_reg)
                pqx_pkg::PQX_DEV_ADDR, pqx_pkg::PQX_DEV_WR: begin
                    shift_next = {shift_reg[6:0], sda_s_reg};
                    cnt_next   = cnt_reg + 4'h1;
                end
                pqx_pkg::PQX_DEV_WR_ACK: begin
                    idx_next = ~idx_reg;
                    if (!idx_reg) begin
                        lo_hold_next = shift_reg;
                    end else begin
                        latch_next  = {shift_reg, lo_hold_reg};
                        strong_next = {shift_reg, lo_hold_reg};
                    end
                end
                pqx_pkg::PQX_DEV_RD_ACK: begin
                    clear_alert = 1'b1;
                    if (sda_s_reg) begin
                        state_next = pqx_pkg::PQX_DEV_IDLE;
                    end
                end
                pqx_pkg::PQX_DEV_IDLE, pqx_pkg::PQX_DEV_ADDR_ACK, pqx_pkg::PQX_DEV_RD: ;
            endcase
        end else if (scl_fall) begin
            unique case (state_reg)
                pqx_pkg::PQX_DEV_ADDR: begin
                    if (cnt_reg == pqx_pkg::BYTE_BITS) begin
                        state_next  = addr_match ? pqx_pkg::PQX_DEV_ADDR_ACK : pqx_pkg::PQX_DEV_IDLE;
                        sda_oe_next = addr_match;
                    end
                end
                pqx_pkg::PQX_DEV_ADDR_ACK, pqx_pkg::PQX_DEV_RD_ACK: begin
                    cnt_next = '0;
                    if (shift_reg[0] || state_reg == pqx_pkg::PQX_DEV_RD_ACK) begin
                        // load next byte, a fresh pin sample for each low byte
                        state_next  = pqx_pkg::PQX_DEV_RD;
                        snap_next   = idx_reg ? snap_reg : pin_s_reg;
                        shift_next  = rd_byte;
                        sda_oe_next = ~rd_byte[7];
                        cnt_next    = pqx_pkg::FIRST_BIT_SENT;
                        idx_next    = ~idx_reg;
                    end else begin
                        state_next  = pqx_pkg::PQX_DEV_WR;
                        sda_oe_next = 1'b0;
                    end
                end
                pqx_pkg::PQX_DEV_WR: begin
                    if (cnt_reg == pqx_pkg::BYTE_BITS) begin
                        state_next  = pqx_pkg::PQX_DEV_WR_ACK;
                        sda_oe_next = 1'b1;
                    end
                end
                pqx_pkg::PQX_DEV_WR_ACK: begin
                    state_next  = pqx_pkg::PQX_DEV_WR;
                    cnt_next    = '0;
                    sda_oe_next = 1'b0;
                    clear_alert = 1'b1;
                end
                pqx_pkg::PQX_DEV_RD: begin
                    if (cnt_reg == pqx_pkg::BYTE_BITS) begin
                        state_next  = pqx_pkg::PQX_DEV_RD_ACK;
                        sda_oe_next = 1'b0;
                    end else begin
                        shift_next  = {shift_reg[6:0], 1'b0};
                        sda_oe_next = ~shift_reg[6];
                        cnt_next    = cnt_reg + 4'h1;
                    end
                end
                pqx_pkg::PQX_DEV_IDLE: ;
            endcase
        end
    end

    // alert: compare inputs against the reference taken at the last access
    always_comb begin
        ref_next       = ref_reg;
        alert_cnt_next = alert_cnt_reg;
        if (clear_alert) begin
            ref_next       = pin_s_reg;
            alert_cnt_next = '0;
        end else if (!mismatch) begin
            alert_cnt_next = '0;
        end else if (alert_cnt_reg != pqx_pkg::ALERT_VALID_CYC) begin
            alert_cnt_next = alert_cnt_reg + 8'h01;
        end
        alert_next = (alert_cnt_next == pqx_pkg::ALERT_VALID_CYC);
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg     <= pqx_pkg::PQX_DEV_IDLE;
            cnt_reg       <= '0;
            shift_reg     <= '0;
            idx_reg       <= 1'b0;
            lo_hold_reg   <= '0;
            snap_reg      <= '0;
            latch_reg     <= pqx_pkg::PORT_LATCH_RESET;
            strong_reg    <= '0;
            sda_oe_reg    <= 1'b0;
            ref_reg       <= pqx_pkg::PORT_LATCH_RESET;
            alert_cnt_reg <= '0;
            alert_reg     <= 1'b0;
        end else begin
            state_reg     <= state_next;
            cnt_reg       <= cnt_next;
            shift_reg     <= shift_next;
            idx_reg       <= idx_next;
            lo_hold_reg   <= lo_hold_next;
            snap_reg      <= snap_next;
            latch_reg     <= latch_next;
            strong_reg    <= strong_next;
            sda_oe_reg    <= sda_oe_next;
            ref_reg       <= ref_next;
            alert_cnt_reg <= alert_cnt_next;
            alert_reg     <= alert_next;
        end
    end

    // a zero latch pulls low; a one is weak high unless the strong pull-up is on
    assign port_low_byte_lines_o   = latch_reg[7:0];
    assign port_low_byte_lines_oe  = ~latch_reg[7:0] | strong_reg[7:0];
    assign port_high_byte_lines_o  = latch_reg[15:8];
    assign port_high_byte_lines_oe = ~latch_reg[15:8] | strong_reg[15:8];
    assign bus.dev_sda_o           = 1'b0;
    assign bus.dev_sda_oe          = sda_oe_reg;
    assign bus.dev_alert_o         = 1'b0;
    assign bus.dev_alert_oe        = alert_reg;

endmodule : pqx_device

/* File: hdl/pqx_pkg.sv */
package pqx_pkg;

    // slave address: fixed upper prefix, low three bits from the select straps
    localparam logic [3:0] ADDR_PREFIX       = 4'h2;  // arbitrary value
    localparam logic [6:0] GENERAL_CALL_ADDR = 7'h00;

    // bit counting on the serial bus
    localparam logic [3:0] BYTE_BITS         = 4'h8;
    localparam logic [3:0] FIRST_BIT_SENT    = 4'h1;
    localparam logic [1:0] FRAME_LAST_BYTE   = 2'h2;

    // timing
    localparam int         CLK_PERIOD_NS        = 100;
    localparam int         ALERT_VALID_DELAY_NS = 4000;
    localparam int         ALERT_VALID_CYC_INT  = (ALERT_VALID_DELAY_NS / CLK_PERIOD_NS < 1) ? 1 :
                                                  ALERT_VALID_DELAY_NS / CLK_PERIOD_NS;
    localparam logic [7:0] ALERT_VALID_CYC      = 8'(ALERT_VALID_CYC_INT);
    localparam int         SCL_PERIOD_NS        = 2500;
    localparam int         SCL_QTR_CYC_INT      = (SCL_PERIOD_NS / CLK_PERIOD_NS / 4 < 1) ? 1 :
                                                  SCL_PERIOD_NS / CLK_PERIOD_NS / 4;
    localparam logic [3:0] SCL_QTR_CYC          = 4'(SCL_QTR_CYC_INT);

    // reset values
    localparam logic [15:0] PORT_LATCH_RESET = 16'hffff;

    typedef enum {
        PQX_DEV_IDLE,
        PQX_DEV_ADDR,
        PQX_DEV_ADDR_ACK,
        PQX_DEV_WR,
        PQX_DEV_WR_ACK,
        PQX_DEV_RD,
        PQX_DEV_RD_ACK
    } pqx_dev_state_t;

    typedef enum {
        PQX_HOST_IDLE,
        PQX_HOST_START,
        PQX_HOST_BIT,
        PQX_HOST_STOP
    } pqx_host_state_t;

endpackage : pqx_pkg

/* File: hdl/pqx_if.sv */
`timescale 1ns/10ps
interface pqx_if;
    // drives from the host end (open drain: enable pulls low)
    logic host_scl_o;
    logic host_scl_oe;
    logic host_sda_o;
    logic host_sda_oe;
    // drives from the device end
    logic dev_sda_o;
    logic dev_sda_oe;
    logic dev_alert_o;
    logic dev_alert_oe;
    // resolved wire levels with pull-ups
    logic scl;
    logic sda;
    logic alert_n;

    assign scl     = ~(host_scl_oe & ~host_scl_o);
    assign sda     = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));
    assign alert_n = ~(dev_alert_oe & ~dev_alert_o);

    modport device (
        input  scl,
        input  sda,
        output dev_sda_o,
        output dev_sda_oe,
        output dev_alert_o,
        output dev_alert_oe
    );

    modport host (
        input  scl,
        input  sda,
        input  alert_n,
        output host_scl_o,
        output host_scl_oe,
        output host_sda_o,
        output host_sda_oe
    );
endinterface : pqx_if

/* File: hdl/pqx_host.sv */
`timescale 1ns/10ps
module pqx_host (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // serial bus
    pqx_if.host              bus,
    // transfer request
    input  wire logic        xfer_req,
    input  wire logic        xfer_rd,
    input  wire logic [6:0]  xfer_addr,
    input  wire logic [15:0] xfer_wdata,
    // transfer result
    output logic             xfer_busy,
    output logic             xfer_done,
    output logic             xfer_nack,
    output logic      [15:0] xfer_rdata,
    output logic             alert_seen
);

    logic                     sda_meta_reg, sda_s_reg, alt_meta_reg, alt_s_reg;
    pqx_pkg::pqx_host_state_t state_reg, state_next;
    logic [3:0]               qtr_reg, qtr_next;
    logic [1:0]               phase_reg, phase_next;
    logic [1:0]               byte_reg, byte_next;
    logic [3:0]               bit_reg, bit_next;
    logic                     rd_reg, rd_next;
    logic [6:0]               addr_reg, addr_next;
    logic [15:0]              wdata_reg, wdata_next;
    logic [15:0]              rx_reg, rx_next;
    logic                     nack_reg, nack_next;
    logic                     done_reg, done_next;
    logic                     scl_oe_reg, scl_oe_next, sda_oe_reg, sda_oe_next;
    logic                     phase_end;
    logic [7:0]               tx_byte;
    logic                     drive_bit, slave_ack_bit, read_bit;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sda_meta_reg <= 1'b1;
            sda_s_reg    <= 1'b1;
            alt_meta_reg <= 1'b1;
            alt_s_reg    <= 1'b1;
        end else begin
            sda_meta_reg <= bus.sda;
            sda_s_reg    <= sda_meta_reg;
            alt_meta_reg <= bus.alert_n;
            alt_s_reg    <= alt_meta_reg;
        end
    end

    assign phase_end     = (qtr_reg == pqx_pkg::SCL_QTR_CYC - 4'h1);
    assign tx_byte       = (byte_reg == 2'h0) ? {addr_reg, rd_reg} :
                           (byte_reg == 2'h1) ? wdata_reg[7:0] : wdata_reg[15:8];
    assign slave_ack_bit = (bit_reg == pqx_pkg::BYTE_BITS) && (!rd_reg || byte_reg == 2'h0);
    assign read_bit      = (bit_reg != pqx_pkg::BYTE_BITS) && rd_reg && byte_reg != 2'h0;
    // value the host puts on sda for the current bit (1 = released)
    always_comb begin
        if (bit_reg == pqx_pkg::BYTE_BITS) begin
            drive_bit = slave_ack_bit | (byte_reg == pqx_pkg::FRAME_LAST_BYTE);
        end else begin
            drive_bit = read_bit | tx_byte[~bit_reg[2:0]];
        end
    end

    always_comb begin
        state_next  = state_reg;
        qtr_next    = phase_end ? '0 : qtr_reg + 4'h1;
        phase_next  = phase_end ? phase_reg + 2'h1 : phase_reg;
        byte_next   = byte_reg;
        bit_next    = bit_reg;
        rd_next     = rd_reg;
        addr_next   = addr_reg;
        wdata_next  = wdata_reg;
        rx_next     = rx_reg;
        nack_next   = nack_reg;
        done_next   = 1'b0;
        scl_oe_next = scl_oe_reg;
        sda_oe_next = sda_oe_reg;
        unique case (state_reg)
            pqx_pkg::PQX_HOST_IDLE: begin
                qtr_next   = '0;
                phase_next = '0;
                if (xfer_req) begin
                    state_next = pqx_pkg::PQX_HOST_START;
                    rd_next    = xfer_rd;
                    addr_next  = xfer_addr;
                    wdata_next = xfer_wdata;
                    nack_next  = 1'b0;
                    byte_next  = '0;
                    bit_next   = '0;
                end
            end
            pqx_pkg::PQX_HOST_START: begin
                if (phase_end && phase_reg == 2'h1) begin
                    sda_oe_next = 1'b1;
                end else if (phase_end && phase_reg == 2'h2) begin
                    scl_oe_next = 1'b1;
                    state_next  = pqx_pkg::PQX_HOST_BIT;
                    phase_next  = '0;
                end
            end
            pqx_pkg::PQX_HOST_BIT: begin
                if (qtr_reg == '0 && phase_reg == 2'h0) begin
                    sda_oe_next = ~drive_bit;
                end
                if (phase_end && phase_reg == 2'h1) begin
                    scl_oe_next = 1'b0;
                end
                if (phase_end && phase_reg == 2'h3) begin
                    scl_oe_next = 1'b1;
                    if (read_bit) begin
                        rx_next = {rx_reg[14:0], sda_s_reg};
                    end
                    if (bit_reg == pqx_pkg::BYTE_BITS) begin
                        bit_next  = '0;
                        byte_next = byte_reg + 2'h1;
                        if (slave_ack_bit && sda_s_reg) begin
                            nack_next  = 1'b1;
                            state_next = pqx_pkg::PQX_HOST_STOP;
                        end else if (byte_reg == pqx_pkg::FRAME_LAST_BYTE) begin
                            state_next = pqx_pkg::PQX_HOST_STOP;
                        end
                    end else begin
                        bit_next = bit_reg + 4'h1;
                    end
                end
            end
            pqx_pkg::PQX_HOST_STOP: begin
                if (qtr_reg == '0 && phase_reg == 2'h0) begin
                    sda_oe_next = 1'b1;
                end
                if (phase_end && phase_reg == 2'h1) begin
                    scl_oe_next = 1'b0;
                end
                if (phase_end && phase_reg == 2'h2) begin
                    sda_oe_next = 1'b0;
                end
                if (phase_end && phase_reg == 2'h3) begin
                    state_next = pqx_pkg::PQX_HOST_IDLE;
                    done_next  = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg  <= pqx_pkg::PQX_HOST_IDLE;
            qtr_reg    <= '0;
            phase_reg  <= '0;
            byte_reg   <= '0;
            bit_reg    <= '0;
            rd_reg     <= 1'b0;
            addr_reg   <= '0;
            wdata_reg  <= '0;
            rx_reg     <= '0;
            nack_reg   <= 1'b0;
            done_reg   <= 1'b0;
            scl_oe_reg <= 1'b0;
            sda_oe_reg <= 1'b0;
        end else begin
            state_reg  <= state_next;
            qtr_reg    <= qtr_next;
            phase_reg  <= phase_next;
            byte_reg   <= byte_next;
            bit_reg    <= bit_next;
            rd_reg     <= rd_next;
            addr_reg   <= addr_next;
            wdata_reg  <= wdata_next;
            rx_reg     <= rx_next;
            nack_reg   <= nack_next;
            done_reg   <= done_next;
            scl_oe_reg <= scl_oe_next;
            sda_oe_reg <= sda_oe_next;
        end
    end

    // first received byte is the low port byte
    assign xfer_rdata      = {rx_reg[7:0], rx_reg[15:8]};
    assign xfer_busy       = (state_reg != pqx_pkg::PQX_HOST_IDLE);
    assign xfer_done       = done_reg;
    assign xfer_nack       = nack_reg;
    assign alert_seen      = ~alt_s_reg;
    assign bus.host_scl_o  = 1'b0;
    assign bus.host_scl_oe = scl_oe_reg;
    assign bus.host_sda_o  = 1'b0;
    assign bus.host_sda_oe = sda_oe_reg;

endmodule : pqx_host

/* File: verification/pqx_checker.sv */
`timescale 1ns/10ps
module pqx_checker (
    // clock and reset
    input wire logic       clk,
    input wire logic       sys_rst,
    // bus wires
    input wire logic       scl,
    input wire logic       dev_sda_o,
    input wire logic       dev_sda_oe,
    input wire logic       dev_alert_o,
    input wire logic       dev_alert_oe,
    // low port byte
    input wire logic [7:0] port_low_byte_lines_o,
    input wire logic [7:0] port_low_byte_lines_oe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    open_drain_a: assert property (!dev_alert_o && !dev_sda_o)
        else $error("open drain level not low");
    reset_idle_a: assert property ($fell(sys_rst) |-> !dev_sda_oe && !dev_alert_oe && port_low_byte_lines_oe == 8'h00)
        else $error("not idle after reset");
    sda_scl_low_a: assert property ($changed(dev_sda_oe) |-> !scl)
        else $error("data changed while clock high");
    sda_release_a: assert property ($rose(dev_sda_oe) |-> ##[1:250] !dev_sda_oe)
        else $error("data line held too long");
    pullup_off_a: assert property ($fell(scl) |-> ##[1:4] (port_low_byte_lines_oe & port_low_byte_lines_o) == 8'h00)
        else $error("strong pull-up past clock fall");
    low_driven_a: assert property ((~port_low_byte_lines_o & ~port_low_byte_lines_oe) == 8'h00)
        else $error("low latch not driven");
    latch_update_a: assert property ($changed(port_low_byte_lines_o) |-> scl)
        else $error("latch changed outside ack high");
    alert_gap_a: assert property ($rose(dev_alert_oe) |-> !$past(dev_alert_oe, 8))
        else $error("alert rose too soon");
    cover property ($rose(dev_alert_oe));
    cover property ($changed(port_low_byte_lines_o));
    cover property ($rose(dev_sda_oe));
endmodule : pqx_checker

/* File: verification/pqx_tb_top.sv */
`timescale 1ns/10ps
module pqx_tb_top;
    logic        clk, sys_rst, xfer_req, xfer_rd, xfer_busy, xfer_done, xfer_nack, alert_seen;
    logic [6:0]  xfer_addr, own;
    logic [15:0] xfer_wdata, xfer_rdata, ext, d;
    logic [7:0]  lo_i, lo_o, lo_oe, hi_i, hi_o, hi_oe;
    logic [2:0]  strap;
    logic [31:0] seed;
    int          n_errors, n_tests;
    pqx_if bus_if ();
    assign own  = {pqx_pkg::ADDR_PREFIX, strap};
    assign lo_i = ext[7:0] & ~(lo_oe & ~lo_o);
    assign hi_i = ext[15:8] & ~(hi_oe & ~hi_o);
    pqx_device pqx_device_inst (.clk(clk), .sys_rst(sys_rst), .bus(bus_if), .addr_select_bit0(strap[0]),
        .addr_select_bit1(strap[1]), .addr_select_bit2(strap[2]), .port_low_byte_lines_i(lo_i),
        .port_low_byte_lines_o(lo_o), .port_low_byte_lines_oe(lo_oe), .port_high_byte_lines_i(hi_i),
        .port_high_byte_lines_o(hi_o), .port_high_byte_lines_oe(hi_oe));
    pqx_host pqx_host_inst (.clk(clk), .sys_rst(sys_rst), .bus(bus_if), .xfer_req(xfer_req), .xfer_rd(xfer_rd),
        .xfer_addr(xfer_addr), .xfer_wdata(xfer_wdata), .xfer_busy(xfer_busy), .xfer_done(xfer_done),
        .xfer_nack(xfer_nack), .xfer_rdata(xfer_rdata), .alert_seen(alert_seen));
    pqx_checker pqx_checker_inst (.clk(clk), .sys_rst(sys_rst), .scl(bus_if.scl), .dev_sda_o(bus_if.dev_sda_o),
        .dev_sda_oe(bus_if.dev_sda_oe), .dev_alert_o(bus_if.dev_alert_o), .dev_alert_oe(bus_if.dev_alert_oe),
        .port_low_byte_lines_o(lo_o), .port_low_byte_lines_oe(lo_oe));
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next
    function automatic logic [15:0] exp_read(input logic [15:0] latch, input logic [15:0] pins);
        return latch & pins;
    endfunction : exp_read
    task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : check
    task automatic xfer(input logic rd, input logic [6:0] a, input logic [15:0] w);
        int n = 0;
        @(posedge clk);
        xfer_req <= 1'b1;
        xfer_rd <= rd;
        xfer_addr <= a;
        xfer_wdata <= w;
        @(posedge clk);
        xfer_req <= 1'b0;
        @(negedge clk);
        check("busy", 16'h0001, {15'h0, xfer_busy});
        while (xfer_done !== 1'b1 && n < 2000) begin
            @(negedge clk);
            n++;
        end
        if (n >= 2000) begin
            $display("MISMATCH xfer_done expected 1 seen 0");
            n_errors++;
            stop_test();
        end
    endtask : xfer
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : stop_test
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        #4000000;
        n_errors++;
        stop_test();
    end
    initial begin
        {sys_rst, xfer_req, xfer_rd, xfer_addr, xfer_wdata} = {2'h2, 24'h0};
        seed = 32'h000118ec;
        strap = seed[2:0];
        ext = 16'hffff;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        @(negedge clk);
        check("port_oe", 16'h0000, {hi_oe, lo_oe});
        for (int i = 0; i < 6; i++) begin
            seed = lfsr_next(seed);
            d = (i == 0) ? 16'h0000 : seed[15:0];
            xfer(1'b0, own, d);
            check("ack", 16'h0000, {15'h0, xfer_nack});
            check("latch", d, {hi_o, lo_o});
            @(posedge clk) ext <= seed[31:16];
            xfer(1'b1, own, 16'h0000);
            check("rdata", exp_read(d, ext), xfer_rdata);
        end
        $display("test data done");
        for (int i = 0; i < 2; i++) begin
            xfer(1'b0, (i == 0) ? {pqx_pkg::ADDR_PREFIX, ~strap} : pqx_pkg::GENERAL_CALL_ADDR, ~d);
            check("nack", 16'h0001, {15'h0, xfer_nack});
            check("latch_kept", d, {hi_o, lo_o});
        end
        $display("test address done");
        @(posedge clk) ext <= 16'hffff;
        xfer(1'b0, own, 16'hffff);
        xfer(1'b1, own, 16'h0000);
        check("alert_idle", 16'h0000, {15'h0, alert_seen});
        @(posedge clk) ext <= 16'hfffe;
        repeat (60) @(negedge clk);
        check("alert_set", 16'h0001, {15'h0, alert_seen});
        xfer(1'b0, {pqx_pkg::ADDR_PREFIX, ~strap}, 16'h0000);
        check("alert_other", 16'h0001, {15'h0, alert_seen});
        xfer(1'b1, own, 16'h0000);
        check("alert_read", 16'h0000, {15'h0, alert_seen});
        @(posedge clk) ext <= 16'hffff;
        repeat (60) @(negedge clk);
        check("alert_again", 16'h0001, {15'h0, alert_seen});
        @(posedge clk) ext <= 16'hfffe;
        repeat (10) @(negedge clk);
        check("alert_restore", 16'h0000, {15'h0, alert_seen});
        $display("test alert done");
        stop_test();
    end
endmodule : pqx_tb_top
